// file: dv/obdp_far_end.sv
// far side model: line transceivers loop tx back to rx, restore button on shared pin
`timescale 1ns/1ps
`default_nettype none
module obdp_far_end (
	input wire logic k_tx,
	input wire logic busplus_tx,
	input wire logic busminus_tx,
	input wire obdp_pkg::obdp_od_s bus_pull,
	input wire logic button_n,
	output logic k_rx,
	output logic pwm_bus_rx,
	output logic vpw_bus_rx,
	output logic settings_restore_n
);
	logic k_line;
	logic bp_line;
	logic bm_line;
	// wire levels; k-line pulled low by an active tx
	assign k_line = ~k_tx;
	assign bp_line = busplus_tx;
	assign bm_line = ~busminus_tx;
	// receivers report recessive as low
	assign k_rx = ~k_line;
	assign pwm_bus_rx = bp_line | ~bm_line;
	assign vpw_bus_rx = bp_line;
	// pull-up wins unless device or button pulls; hold length set by bench
	assign settings_restore_n = button_n & bus_pull.oe_n;
endmodule : obdp_far_end
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the pin signalling block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, k_tx, l_tx, k_rx, busplus_tx, busminus_tx;
	logic busplus_supply_sel, pwm_bus_rx, vpw_bus_rx, status_indicator, host_activity_ind_n;
	logic settings_restore_n, ext_power_ctl, sleep_in, swc_tool_load_en, uart_tx_level, button_n;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, gp_in, ln;
	logic [1:0] bresp, rresp;
	obdp_pkg::obdp_od_s bus_activity_ind_n, swc_mode_sel0, swc_mode_sel1, uart_tx;
	obdp_pkg::obdp_gp_s [3:0] general_purpose_pin;
	logic [33:0] expq[$];
	int failures, compares, n;
	logic pl;
	logic [31:0] cw;
	obdp_top #(.SLEEP_PERIOD_CYC(32'd40), .STATUS_PULSE_CYC(32'd4),
		.RESTORE_HOLD_CYC(32'd10)) dut (.*);
	obdp_far_end far (.k_tx(k_tx), .busplus_tx(busplus_tx), .busminus_tx(busminus_tx),
		.bus_pull(bus_activity_ind_n), .button_n(button_n), .k_rx(k_rx),
		.pwm_bus_rx(pwm_bus_rx), .vpw_bus_rx(vpw_bus_rx),
		.settings_restore_n(settings_restore_n));
	////////////////////////////////////////////////////////////////////////////////
	// compare and verdict
	task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic final_report();
		$display("checks %0d mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report
	// read results leave the queue in order of arrival
	always @(posedge aclk) begin
		if (rvalid && rready) begin
			chk("rdata", {rresp, rdata}, expq.pop_front());
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// bus master; request held until each ready is sampled high
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		chk("bresp", 34'(bresp), 34'(er));
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		expq.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	// status word as the pins and line loopback dictate
	function automatic logic [33:0] st(input logic slp, input logic arm);
		return {22'h0, gp_in, 3'h0, arm, ln[2], ln[2] | ln[3], ~ln[0], slp};
	endfunction : st
	// arguments are taken at the call, so callers let the pins settle first
	task automatic pins(input logic [15:0] s, input logic [15:0] e);
		chk("pins", 34'(s), 34'(e));
	endtask : pins
	////////////////////////////////////////////////////////////////////////////////
	// clock, watchdog
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	initial begin
		#(25 * 30000);
		failures++;
		final_report();
	end
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, uart_tx_level} = '0;
		{awaddr, araddr, wdata, ln} = '0;
		{aresetn, sleep_in, button_n, wstrb, failures, compares} = {3'b011, 4'hF, 64'd0};
		gp_in = 4'h0;
		void'($urandom(32'hbc59));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		// defaults after reset
		repeat (3) @(posedge aclk);
		pins({busplus_supply_sel, status_indicator, host_activity_ind_n, ext_power_ctl,
			bus_activity_ind_n.oe_n, swc_tool_load_en, general_purpose_pin[0][1:0]},
			8'b1111_1010);
		for (int a = 0; a < 5; a++) rd(8'(4 * a), 34'h0);
		$display("test defaults done");
		// every line drive pattern, looped back through the receivers
		for (int i = 0; i < 16; i++) begin
			ln = 4'(i);
			wr(obdp_pkg::ADDR_LINE, 32'(i), obdp_pkg::RESP_OKAY);
			repeat (3) @(posedge aclk);
			pins({k_tx, l_tx, busplus_tx, busminus_tx}, {ln[0], ln[1], ln[2], ln[3]});
			rd(obdp_pkg::ADDR_STATUS, st(1'b0, 1'b0));
		end
		$display("test lines done");
		// random awake control words
		for (int i = 0; i < 12; i++) begin
			cw = $urandom & 32'h7C9;
			wr(obdp_pkg::ADDR_CTRL, cw, obdp_pkg::RESP_OKAY);
			repeat (3) @(posedge aclk);
			pins({busplus_supply_sel, swc_tool_load_en, host_activity_ind_n, bus_activity_ind_n,
				ext_power_ctl, swc_mode_sel0.oe_n, swc_mode_sel1.oe_n}, {~cw[0], cw[6],
				~cw[9], 1'b0, ~cw[10], ~cw[3], cw[7], cw[8]});
		end
		$display("test control done");
		// sleep by default active-low input, then pulse count over one period
		wr(obdp_pkg::ADDR_CTRL, 32'h182, obdp_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		pins({status_indicator, ext_power_ctl}, 8'h3);
		sleep_in <= 1'b0;
		repeat (3) @(posedge aclk);
		pins({ext_power_ctl, swc_mode_sel0.oe_n, swc_mode_sel1.oe_n}, 8'h0);
		rd(obdp_pkg::ADDR_STATUS, st(1'b1, 1'b0));
		n = 0;
		repeat (40) begin
			@(posedge aclk);
			n += int'(status_indicator);
		end
		chk("pulse", 34'(n), 34'(4));
		wr(obdp_pkg::ADDR_CTRL, 32'h186, obdp_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		pins({status_indicator, ext_power_ctl}, 8'h3);
		sleep_in <= 1'b1;
		repeat (3) @(posedge aclk);
		// first sleep pulse starts at entry, power already dropped
		pins({status_indicator, ext_power_ctl}, 8'h2);
		wr(obdp_pkg::ADDR_CTRL, 32'h010, obdp_pkg::RESP_OKAY);
		sleep_in <= 1'b0;
		repeat (3) @(posedge aclk);
		pins({status_indicator, ext_power_ctl}, 8'h0);
		$display("test sleep done");
		// gpio: pull-ups on inputs, open-drain outputs, indicator priority
		gp_in <= 4'($urandom);
		wr(obdp_pkg::ADDR_CTRL, 32'h0, obdp_pkg::RESP_OKAY);
		wr(obdp_pkg::ADDR_GP_PULL, 32'hF, obdp_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		pins(16'(general_purpose_pin), 16'h06DB);
		wr(obdp_pkg::ADDR_GP_DIR, 32'h3F, obdp_pkg::RESP_OKAY);
		wr(obdp_pkg::ADDR_GP_OUT, 32'h05, obdp_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		pins({general_purpose_pin, host_activity_ind_n, bus_activity_ind_n.oe_n},
			14'b000_010_000_010_11);
		wr(obdp_pkg::ADDR_CTRL, 32'h020, obdp_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		pins({host_activity_ind_n, bus_activity_ind_n}, 8'h0);
		rd(obdp_pkg::ADDR_STATUS, st(1'b0, 1'b0));
		$display("test gpio done");
		// uart pin follows its level one cycle later, never driven high
		for (int i = 0; i < 20; i++) begin
			@(posedge aclk);
			if (i > 0) chk("uart", 34'(uart_tx), {33'h0, pl});
			pl = uart_tx_level;
			uart_tx_level <= 1'($urandom);
		end
		// unmapped place and read-only status
		wr(8'h40, 32'h1, obdp_pkg::RESP_SLVERR);
		rd(8'h40, {obdp_pkg::RESP_SLVERR, 32'h0});
		wr(obdp_pkg::ADDR_STATUS, 32'h1F, obdp_pkg::RESP_OKAY);
		rd(obdp_pkg::ADDR_STATUS, st(1'b0, 1'b0));
		$display("test bus errors done");
		// restore: hold past the limit, release, settings cleared
		wr(obdp_pkg::ADDR_GP_DIR, 32'h0, obdp_pkg::RESP_OKAY);
		wr(obdp_pkg::ADDR_CTRL, 32'h040, obdp_pkg::RESP_OKAY);
		button_n <= 1'b0;
		repeat (15) @(posedge aclk);
		rd(obdp_pkg::ADDR_STATUS, st(1'b0, 1'b1));
		button_n <= 1'b1;
		// release seen, soft reset, settings cleared, then the pin follows
		repeat (4) @(posedge aclk);
		pins({swc_tool_load_en}, 8'h0);
		rd(obdp_pkg::ADDR_CTRL, 34'h0);
		$display("test restore done");
		// reset in mid run clears lines
		wr(obdp_pkg::ADDR_LINE, 32'hF, obdp_pkg::RESP_OKAY);
		aresetn <= 1'b0;
		repeat (80) @(posedge aclk);
		aresetn <= 1'b1;
		ln = 4'h0;
		repeat (3) @(posedge aclk);
		pins({k_tx, busplus_tx}, 8'h0);
		rd(obdp_pkg::ADDR_LINE, 34'h0);
		$display("test reset done");
		final_report();
	end
endmodule : tb
`default_nettype wire

// file: hw/obdp_pkg.sv
// constants, register map and pin carriers for the obd pin signalling block
package obdp_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned XTAL_HZ = 16_000_000; // crystal rate that the system clock stands in for
	localparam int unsigned STATUS_PULSE_MS = 5;
	localparam int unsigned SLEEP_PERIOD_S = 3;
	localparam int unsigned RESTORE_HOLD_S = 5;
	localparam int unsigned RESET_MIN_NS = 2000;
	localparam logic [31:0] STATUS_PULSE_CYC = 32'(STATUS_PULSE_MS * (CLK_HZ / 1000));
	localparam logic [31:0] SLEEP_PERIOD_CYC = 32'(SLEEP_PERIOD_S * CLK_HZ);
	localparam logic [31:0] RESTORE_HOLD_CYC = 32'(RESTORE_HOLD_S * CLK_HZ);
	localparam logic [31:0] RESET_MIN_CYC = 32'((RESET_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000);

	// register offsets (byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_LINE = 8'h04;
	localparam logic [7:0] ADDR_GP_DIR = 8'h08;
	localparam logic [7:0] ADDR_GP_OUT = 8'h0C;
	localparam logic [7:0] ADDR_GP_PULL = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;

	// ctrl fields
	localparam int CTRL_VPW = 0;
	localparam int CTRL_SLEEP_EN = 1;
	localparam int CTRL_SLEEP_POL_HI = 2;
	localparam int CTRL_PWR_POL_INV = 3;
	localparam int CTRL_SLEEP_CMD = 4;
	localparam int CTRL_IND_DIS = 5;
	localparam int CTRL_SWC_LOAD = 6;
	localparam int CTRL_SWC_MODE0 = 7;
	localparam int CTRL_SWC_MODE1 = 8;
	localparam int CTRL_HOST_ACT = 9;
	localparam int CTRL_BUS_ACT = 10;
	localparam int CTRL_W = 11;
	// line fields
	localparam int LINE_K_LOW = 0;
	localparam int LINE_L_LOW = 1;
	localparam int LINE_BP_DOM = 2;
	localparam int LINE_BM_DOM = 3;
	localparam int LINE_W = 4;
	// status fields
	localparam int STAT_ASLEEP = 0;
	localparam int STAT_K_HIGH = 1;
	localparam int STAT_PWM_DOM = 2;
	localparam int STAT_VPW_DOM = 3;
	localparam int STAT_RESTORE_ARMED = 4;
	localparam int STAT_GP_IN = 8;

	// general purpose pins; gp_out bits 4 and 5 take over the indicator pins
	localparam int NGP = 4;
	localparam int GP_HOST_BIT = 4;
	localparam int GP_BUS_BIT = 5;
	localparam int GP_W = 6;

	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
	localparam logic [LINE_W-1:0] LINE_RST = 4'h0;
	localparam logic [GP_W-1:0] GP_RST = 6'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// open-drain pin: oe_n low while the pin is pulled
	typedef struct packed {
		logic out;
		logic oe_n;
	} obdp_od_s;

	typedef struct packed {
		logic out;
		logic oe_n;
		logic pull_up;
	} obdp_gp_s;

	typedef enum logic [1:0] {RS_IDLE, RS_HOLD, RS_ARMED} obdp_restore_e;
endpackage : obdp_pkg

// file: hw/obdp_top.sv
// pin signalling, indicators, sleep and gpio control behind an axi4-lite slave
// How it works
// - k tx pin high pulls k-line low
// - l tx pin high pulls l-line low
// - bus+ tx high makes bus+ dominant
// - bus- tx high makes bus- low, dominant
// - supply select high for pwm, low vpw
// - status high running, sleep 5 ms per 3 s
// - host activity indicator is active low
// - shared pin: activity out, restore request in
// - power control high awake, polarity configurable
// - reset low at least 2 us resets
// - enabled sleep input, default active low
// - tool load output follows load enable
// - swc mode pins pulled low while asleep
// - gp pins reset as inputs, pull-up only inputs
// - gp outputs are open-drain, pull low only
// - indicator function wins over gp control
// - uart tx is open-drain, low only
// - timing comes from one system clock
// - restore held 5 s: defaults then soft reset
`timescale 1ns/1ps
`default_nettype none
module obdp_top #(
	parameter logic [31:0] SLEEP_PERIOD_CYC = obdp_pkg::SLEEP_PERIOD_CYC,
	parameter logic [31:0] STATUS_PULSE_CYC = obdp_pkg::STATUS_PULSE_CYC,
	parameter logic [31:0] RESTORE_HOLD_CYC = obdp_pkg::RESTORE_HOLD_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic k_tx,
	output logic l_tx,
	input wire logic k_rx,
	output logic busplus_tx,
	output logic busminus_tx,
	output logic busplus_supply_sel,
	input wire logic pwm_bus_rx,
	input wire logic vpw_bus_rx,
	output logic status_indicator,
	output logic host_activity_ind_n,
	output obdp_pkg::obdp_od_s bus_activity_ind_n,
	input wire logic settings_restore_n,
	output logic ext_power_ctl,
	input wire logic sleep_in,
	output logic swc_tool_load_en,
	output obdp_pkg::obdp_od_s swc_mode_sel0,
	output obdp_pkg::obdp_od_s swc_mode_sel1,
	output obdp_pkg::obdp_gp_s [obdp_pkg::NGP-1:0] general_purpose_pin,
	input wire logic [obdp_pkg::NGP-1:0] gp_in,
	input wire logic uart_tx_level,
	output obdp_pkg::obdp_od_s uart_tx
);

	////////////////////////////////////////////////////////////////////////////
	// state
	logic [obdp_pkg::CTRL_W-1:0] ctrl;
	logic [obdp_pkg::LINE_W-1:0] line;
	logic [obdp_pkg::GP_W-1:0] gp_dir;
	logic [obdp_pkg::GP_W-1:0] gp_out;
	logic [obdp_pkg::NGP-1:0] gp_pull;
	logic aw_hold, w_hold;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic asleep;
	logic [31:0] slp_cnt;
	logic [31:0] hold_cnt;
	obdp_pkg::obdp_restore_e rs_state;
	logic soft_rst;
	logic cfg_rst;

	////////////////////////////////////////////////////////////////////////////
	// axi write path: address and data taken in either order
	logic aw_take, w_take, have_aw, have_w, do_write;
	logic next_aw_hold, next_w_hold, next_bvalid;
	logic [7:0] waddr;
	logic [31:0] wval, wmask;
	logic wr_ctrl, wr_line, wr_dir, wr_out, wr_pull, wr_stat, wr_hit;
	assign aw_take = awvalid & awready;
	assign w_take = wvalid & wready;
	assign have_aw = aw_hold | aw_take;
	assign have_w = w_hold | w_take;
	assign do_write = have_aw & have_w;
	assign next_aw_hold = have_aw & ~do_write;
	assign next_w_hold = have_w & ~do_write;
	assign next_bvalid = do_write | (bvalid & ~bready);
	assign waddr = aw_take ? awaddr : aw_addr_q;
	assign wval = w_take ? wdata : w_data_q;
	assign wmask = w_take ? {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}}
		: {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

	// register decode; the status word is read-only and ignores writes
	assign wr_ctrl = do_write & (waddr == obdp_pkg::ADDR_CTRL);
	assign wr_line = do_write & (waddr == obdp_pkg::ADDR_LINE);
	assign wr_dir = do_write & (waddr == obdp_pkg::ADDR_GP_DIR);
	assign wr_out = do_write & (waddr == obdp_pkg::ADDR_GP_OUT);
	assign wr_pull = do_write & (waddr == obdp_pkg::ADDR_GP_PULL);
	assign wr_stat = do_write & (waddr == obdp_pkg::ADDR_STATUS);
	assign wr_hit = wr_ctrl | wr_line | wr_dir | wr_out | wr_pull | wr_stat;

	// byte-lane merge for each writable register
	logic [31:0] next_ctrl_w, next_line_w, next_dir_w, next_out_w, next_pull_w;
	assign next_ctrl_w = (32'(ctrl) & ~wmask) | (wval & wmask);
	assign next_line_w = (32'(line) & ~wmask) | (wval & wmask);
	assign next_dir_w = (32'(gp_dir) & ~wmask) | (wval & wmask);
	assign next_out_w = (32'(gp_out) & ~wmask) | (wval & wmask);
	assign next_pull_w = (32'(gp_pull) & ~wmask) | (wval & wmask);

	// handshake flops; readies drop while a response is owed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			bvalid <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bresp <= obdp_pkg::RESP_OKAY;
		end else begin
			aw_hold <= next_aw_hold;
			w_hold <= next_w_hold;
			bvalid <= next_bvalid;
			awready <= ~next_aw_hold & ~next_bvalid;
			wready <= ~next_w_hold & ~next_bvalid;
			if (do_write) begin
				bresp <= wr_hit ? obdp_pkg::RESP_OKAY : obdp_pkg::RESP_SLVERR;
			end
		end
	end

	// payload capture needs no reset
	always_ff @(posedge aclk) begin
		if (aw_take) begin
			aw_addr_q <= awaddr;
		end
		if (w_take) begin
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// configuration; restore release wipes it back to defaults
	assign cfg_rst = ~aresetn | soft_rst;
	always_ff @(posedge aclk) begin
		if (cfg_rst) begin
			ctrl <= obdp_pkg::CTRL_RST;
			line <= obdp_pkg::LINE_RST;
			gp_dir <= obdp_pkg::GP_RST;
			gp_out <= obdp_pkg::GP_RST;
			gp_pull <= obdp_pkg::GP_RST[obdp_pkg::NGP-1:0];
		end else begin
			if (wr_ctrl) ctrl <= next_ctrl_w[obdp_pkg::CTRL_W-1:0];
			if (wr_line) line <= next_line_w[obdp_pkg::LINE_W-1:0];
			if (wr_dir) gp_dir <= next_dir_w[obdp_pkg::GP_W-1:0];
			if (wr_out) gp_out <= next_out_w[obdp_pkg::GP_W-1:0];
			if (wr_pull) gp_pull <= next_pull_w[obdp_pkg::NGP-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read path
	logic ar_take, next_rvalid, rd_hit;
	logic [31:0] status_word, rd_word;
	assign ar_take = arvalid & arready;
	assign next_rvalid = ar_take | (rvalid & ~rready);
	assign status_word = {20'h0, gp_in, 3'h0,
		rs_state == obdp_pkg::RS_ARMED,
		vpw_bus_rx,
		pwm_bus_rx,
		~k_rx,
		asleep};
	assign rd_hit = (araddr == obdp_pkg::ADDR_CTRL) | (araddr == obdp_pkg::ADDR_LINE)
		| (araddr == obdp_pkg::ADDR_GP_DIR) | (araddr == obdp_pkg::ADDR_GP_OUT)
		| (araddr == obdp_pkg::ADDR_GP_PULL) | (araddr == obdp_pkg::ADDR_STATUS);
	assign rd_word = (araddr == obdp_pkg::ADDR_CTRL) ? 32'(ctrl)
		: (araddr == obdp_pkg::ADDR_LINE) ? 32'(line)
		: (araddr == obdp_pkg::ADDR_GP_DIR) ? 32'(gp_dir)
		: (araddr == obdp_pkg::ADDR_GP_OUT) ? 32'(gp_out)
		: (araddr == obdp_pkg::ADDR_GP_PULL) ? 32'(gp_pull)
		: (araddr == obdp_pkg::ADDR_STATUS) ? status_word : 32'h0000_0000;

	// one read in flight; data frozen until rready
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			arready <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= obdp_pkg::RESP_OKAY;
		end else begin
			rvalid <= next_rvalid;
			arready <= ~next_rvalid;
			if (ar_take) begin
				rdata <= rd_word;
				rresp <= rd_hit ? obdp_pkg::RESP_OKAY : obdp_pkg::RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sleep: software command or enabled pin with chosen polarity
	logic next_asleep;
	assign next_asleep = ctrl[obdp_pkg::CTRL_SLEEP_CMD] | (ctrl[obdp_pkg::CTRL_SLEEP_EN]
		& (sleep_in == ctrl[obdp_pkg::CTRL_SLEEP_POL_HI]));

	// period counter restarts on every entry so the first pulse is immediate
	logic [31:0] next_slp_cnt;
	assign next_slp_cnt = (!asleep || slp_cnt == SLEEP_PERIOD_CYC - 32'h1) ? 32'h0
		: slp_cnt + 32'h1;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			asleep <= 1'b0;
			slp_cnt <= 32'h0;
		end else begin
			asleep <= next_asleep;
			slp_cnt <= next_slp_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// restore request: only sampled while the shared pin is released
	logic pin_released, restore_low;
	obdp_pkg::obdp_restore_e next_rs_state;
	logic [31:0] next_hold_cnt;
	assign pin_released = bus_activity_ind_n.oe_n;
	assign restore_low = pin_released & ~settings_restore_n;
	assign next_hold_cnt = !restore_low ? 32'h0
		: (hold_cnt == RESTORE_HOLD_CYC) ? hold_cnt : hold_cnt + 32'h1;

	always_comb begin
		next_rs_state = rs_state;
		case (rs_state)
			obdp_pkg::RS_IDLE: begin
				if (restore_low) next_rs_state = obdp_pkg::RS_HOLD;
			end
			obdp_pkg::RS_HOLD: begin
				if (!restore_low) next_rs_state = obdp_pkg::RS_IDLE;
				else if (hold_cnt == RESTORE_HOLD_CYC - 32'h1) next_rs_state = obdp_pkg::RS_ARMED;
			end
			obdp_pkg::RS_ARMED: begin
				// a release after the hold triggers defaults and soft reset
				if (settings_restore_n) next_rs_state = obdp_pkg::RS_IDLE;
			end
			default: next_rs_state = obdp_pkg::RS_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rs_state <= obdp_pkg::RS_IDLE;
			hold_cnt <= 32'h0;
			soft_rst <= 1'b0;
		end else begin
			rs_state <= next_rs_state;
			hold_cnt <= next_hold_cnt;
			soft_rst <= (rs_state == obdp_pkg::RS_ARMED) & settings_restore_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin drive values; indicators own their pins until disabled
	logic ind_dis, bus_pull, next_status;
	assign ind_dis = ctrl[obdp_pkg::CTRL_IND_DIS];
	// the shared pin stays released while armed so the release is seen
	assign bus_pull = (rs_state == obdp_pkg::RS_IDLE) & (ind_dis
		? gp_dir[obdp_pkg::GP_BUS_BIT] & ~gp_out[obdp_pkg::GP_BUS_BIT]
		: ctrl[obdp_pkg::CTRL_BUS_ACT]);
	assign next_status = ~next_asleep | (next_slp_cnt < STATUS_PULSE_CYC);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			k_tx <= 1'b0;
			l_tx <= 1'b0;
			busplus_tx <= 1'b0;
			busminus_tx <= 1'b0;
			busplus_supply_sel <= 1'b1;
			status_indicator <= 1'b1;
			host_activity_ind_n <= 1'b1;
			bus_activity_ind_n <= '{out: 1'b0, oe_n: 1'b1};
			ext_power_ctl <= 1'b1;
			swc_tool_load_en <= 1'b0;
			swc_mode_sel0 <= '{out: 1'b0, oe_n: 1'b1};
			swc_mode_sel1 <= '{out: 1'b0, oe_n: 1'b1};
			uart_tx <= '{out: 1'b0, oe_n: 1'b1};
		end else begin
			k_tx <= line[obdp_pkg::LINE_K_LOW];
			l_tx <= line[obdp_pkg::LINE_L_LOW];
			busplus_tx <= line[obdp_pkg::LINE_BP_DOM];
			busminus_tx <= line[obdp_pkg::LINE_BM_DOM];
			busplus_supply_sel <= ~ctrl[obdp_pkg::CTRL_VPW];
			status_indicator <= next_status;
			host_activity_ind_n <= ind_dis ? gp_out[obdp_pkg::GP_HOST_BIT]
				: ~ctrl[obdp_pkg::CTRL_HOST_ACT];
			bus_activity_ind_n <= '{out: 1'b0, oe_n: ~bus_pull};
			ext_power_ctl <= ~next_asleep ^ ctrl[obdp_pkg::CTRL_PWR_POL_INV];
			swc_tool_load_en <= ctrl[obdp_pkg::CTRL_SWC_LOAD];
			// mode pins pull low while asleep whatever the mode says
			swc_mode_sel0 <= '{out: 1'b0,
				oe_n: ~(next_asleep | ~ctrl[obdp_pkg::CTRL_SWC_MODE0])};
			swc_mode_sel1 <= '{out: 1'b0,
				oe_n: ~(next_asleep | ~ctrl[obdp_pkg::CTRL_SWC_MODE1])};
			uart_tx <= '{out: 1'b0, oe_n: uart_tx_level};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// dedicated gp pins: input with optional pull-up, or open-drain low
	genvar gi;
	generate
		for (gi = 0; gi < obdp_pkg::NGP; gi++) begin : g_gp
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					general_purpose_pin[gi] <= '{out: 1'b0, oe_n: 1'b1, pull_up: 1'b0};
				end else begin
					general_purpose_pin[gi] <= '{out: 1'b0,
						oe_n: ~(gp_dir[gi] & ~gp_out[gi]),
						pull_up: ~gp_dir[gi] & gp_pull[gi]};
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_sleep_steady;
		asleep [*2];
	endsequence

	sequence s_restore_release;
		(rs_state == obdp_pkg::RS_ARMED) && settings_restore_n;
	endsequence

	property p_k_tx;
		@(posedge aclk) disable iff (!aresetn) $rose(line[obdp_pkg::LINE_K_LOW]) |=> k_tx;
	endproperty
	a_k_tx: assert property (p_k_tx) else $error("k tx not raised for line low");

	property p_l_tx;
		@(posedge aclk) disable iff (!aresetn) $fell(line[obdp_pkg::LINE_L_LOW]) |=> !l_tx;
	endproperty
	a_l_tx: assert property (p_l_tx) else $error("l tx not released");

	property p_bus_pair;
		@(posedge aclk) disable iff (!aresetn)
		$stable(line) |-> (busplus_tx == line[obdp_pkg::LINE_BP_DOM])
			&& (busminus_tx == line[obdp_pkg::LINE_BM_DOM]);
	endproperty
	a_bus_pair: assert property (p_bus_pair) else $error("bus tx pins disagree");

	property p_supply;
		@(posedge aclk) disable iff (!aresetn)
		ctrl[obdp_pkg::CTRL_VPW] [*2] |-> !busplus_supply_sel;
	endproperty
	a_supply: assert property (p_supply) else $error("supply select wrong for vpw");

	property p_awake_status;
		@(posedge aclk) disable iff (!aresetn) !next_asleep |=> status_indicator;
	endproperty
	a_awake_status: assert property (p_awake_status) else $error("status low while awake");

	property p_sleep_pulse_end;
		@(posedge aclk) disable iff (!aresetn)
		s_sleep_steady ##0 (slp_cnt == STATUS_PULSE_CYC - 32'h1) ##1 asleep |-> !status_indicator;
	endproperty
	a_sleep_pulse_end: assert property (p_sleep_pulse_end) else $error("sleep pulse too long");

	property p_swc_sleep;
		@(posedge aclk) disable iff (!aresetn)
		asleep |-> !swc_mode_sel0.oe_n && !swc_mode_sel1.oe_n;
	endproperty
	a_swc_sleep: assert property (p_swc_sleep) else $error("swc mode not low in sleep");

	property p_pwr_sleep;
		@(posedge aclk) disable iff (!aresetn)
		asleep && !ctrl[obdp_pkg::CTRL_PWR_POL_INV] && $stable(ctrl) |-> !ext_power_ctl;
	endproperty
	a_pwr_sleep: assert property (p_pwr_sleep) else $error("power control high in sleep");

	property p_gp_pull;
		@(posedge aclk) disable iff (!aresetn)
		general_purpose_pin[0].pull_up |-> general_purpose_pin[0].oe_n;
	endproperty
	a_gp_pull: assert property (p_gp_pull) else $error("pull-up on driven gp pin");

	property p_restore;
		@(posedge aclk) disable iff (!aresetn) s_restore_release |=> soft_rst ##1 (ctrl == '0);
	endproperty
	a_restore: assert property (p_restore) else $error("restore did not reset settings");

endmodule : obdp_top
`default_nettype wire
